// [rtl/gfs_gpio_function_select.sv]
`timescale 1ns/1ps
module gfs_gpio_function_select
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  input wire logic reference_input_0_precise_fail,
  input wire logic reference_input_0_cycle_fail,
  input wire logic reference_input_0_coarse_fail,
  input wire logic reference_input_0_guard_soak,
  output logic [15:0] post_divider_stop,
  output logic [7:0] diff_output_enable,
  output logic [7:0] single_ended_output_enable,
  output logic irq
);
  //////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] pin_role_select_reg_q [gfs_pkg::NUM_PINS];
  logic [7:0] diff_output_enable_reg_q;
  logic [7:0] single_ended_output_enable_reg_q;
  logic [15:0] post_divider_stop_reg_q;
  logic [3:0] irq_status_q;
  logic [3:0] irq_mask_q;
  logic [3:0] ev_prev_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic [15:0] stop_eff_q;
  logic [7:0] diff_eff_q;
  logic [7:0] se_eff_q;
  logic [3:0] ev_now;
  logic [3:0] ev_rise;
  logic [3:0] w1c;
  logic wr_fire;
  logic req_take;
  logic [15:0] stop_vec [gfs_pkg::NUM_PINS];
  logic [7:0] diff_vec [gfs_pkg::NUM_PINS];
  logic [7:0] se_vec [gfs_pkg::NUM_PINS];
  logic [15:0] stop_any;
  logic [7:0] diff_any;
  logic [7:0] se_any;

  //////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, write lands on the edge waitrequest is low
  assign req_take = (avs_read || avs_write) && wait_q;
  assign wr_fire = avs_write && !wait_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wait_q <= 1'b1;
    end
    else if (req_take)
    begin
      wait_q <= 1'b0;
    end
    else
    begin
      wait_q <= 1'b1;
    end
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (avs_address[7:5] == 3'b000)
    begin
      rdata_d[7:0] = pin_role_select_reg_q[avs_address[4:2]];
    end
    else
    begin
      case ({avs_address[7:2], 2'b00})
        gfs_pkg::OFS_DIFF_EN: rdata_d[7:0] = diff_output_enable_reg_q;
        gfs_pkg::OFS_SE_EN: rdata_d[7:0] = single_ended_output_enable_reg_q;
        gfs_pkg::OFS_STOP: rdata_d[15:0] = post_divider_stop_reg_q;
        gfs_pkg::OFS_IRQ_STAT: rdata_d[3:0] = irq_status_q;
        gfs_pkg::OFS_IRQ_MASK: rdata_d[3:0] = irq_mask_q;
        gfs_pkg::OFS_EFF_EN: rdata_d[15:0] = {se_eff_q, diff_eff_q};
        gfs_pkg::OFS_EFF_STOP: rdata_d[15:0] = stop_eff_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (req_take && avs_read)
    begin
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software-written control registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < gfs_pkg::NUM_PINS; i++)
      begin
        pin_role_select_reg_q[i] <= gfs_pkg::RST_ROLE;
      end
    end
    else if (wr_fire && avs_address[7:5] == 3'b000)
    begin
      pin_role_select_reg_q[avs_address[4:2]] <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      diff_output_enable_reg_q <= gfs_pkg::RST_OUT_EN;
      single_ended_output_enable_reg_q <= gfs_pkg::RST_OUT_EN;
      post_divider_stop_reg_q <= gfs_pkg::RST_STOP;
      irq_mask_q <= gfs_pkg::RST_EV;
    end
    else if (wr_fire)
    begin
      case ({avs_address[7:2], 2'b00})
        gfs_pkg::OFS_DIFF_EN: diff_output_enable_reg_q <= avs_writedata[7:0];
        gfs_pkg::OFS_SE_EN: single_ended_output_enable_reg_q <= avs_writedata[7:0];
        gfs_pkg::OFS_STOP: post_divider_stop_reg_q <= avs_writedata[15:0];
        gfs_pkg::OFS_IRQ_MASK: irq_mask_q <= avs_writedata[3:0];
        default: irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt: rising indicator edges set sticky bits, set beats clear
  assign ev_now = {reference_input_0_guard_soak, reference_input_0_coarse_fail, reference_input_0_cycle_fail, reference_input_0_precise_fail};
  assign ev_rise = ev_now & ~ev_prev_q;
  assign w1c = (wr_fire && {avs_address[7:2], 2'b00} == gfs_pkg::OFS_IRQ_STAT) ?
               avs_writedata[3:0] : 4'h0;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ev_prev_q <= gfs_pkg::RST_EV;
      irq_status_q <= gfs_pkg::RST_EV;
      irq_q <= 1'b0;
    end
    else
    begin
      ev_prev_q <= ev_now;
      irq_status_q <= (irq_status_q & ~w1c) | ev_rise;
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-pin role decoders
  for (genvar g = 0; g < gfs_pkg::NUM_PINS; g++)
  begin : g_pin
    gfs_pin_role_decode u_dec
    (
      .clk(clk),
      .rst_n(rst_n),
      .role(pin_role_select_reg_q[g]),
      .pin_level(pin_in[g]),
      .irq_level(irq_q),
      .precise_fail(reference_input_0_precise_fail),
      .cycle_fail(reference_input_0_cycle_fail),
      .coarse_fail(reference_input_0_coarse_fail),
      .guard_soak(reference_input_0_guard_soak),
      .stop_vec_q(stop_vec[g]),
      .diff_vec_q(diff_vec[g]),
      .se_vec_q(se_vec[g]),
      .drive_level_q(pin_out[g]),
      .drive_en_q(pin_oe[g])
    );
  end

  always_comb
  begin
    stop_any = gfs_pkg::RST_STOP;
    diff_any = gfs_pkg::RST_OUT_EN;
    se_any = gfs_pkg::RST_OUT_EN;
    for (int i = 0; i < gfs_pkg::NUM_PINS; i++)
    begin
      stop_any = stop_any | stop_vec[i];
      diff_any = diff_any | diff_vec[i];
      se_any = se_any | se_vec[i];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // effective controls: pin levels ORed with register bits
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stop_eff_q <= gfs_pkg::RST_STOP;
      diff_eff_q <= gfs_pkg::RST_OUT_EN;
      se_eff_q <= gfs_pkg::RST_OUT_EN;
    end
    else
    begin
      stop_eff_q <= post_divider_stop_reg_q | stop_any;
      diff_eff_q <= diff_output_enable_reg_q | diff_any;
      se_eff_q <= single_ended_output_enable_reg_q | se_any;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign post_divider_stop = stop_eff_q;
  assign diff_output_enable = diff_eff_q;
  assign single_ended_output_enable = se_eff_q;
  assign irq = irq_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  chk_role_write_store: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_fire && avs_address == gfs_pkg::OFS_ROLE0)
    |=> pin_role_select_reg_q[0] == $past(avs_writedata[7:0]))
    else $error("pin 0 role register did not take the written code");

  chk_stop_first_code: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_role_select_reg_q[5] == 8'h44 && pin_in[5])[*2] |=> post_divider_stop[3])
    else $error("code 0x44 did not stop synth 0 divider C bit1");

  chk_stop_last_code: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_role_select_reg_q[5] == 8'h5F && pin_in[5])[*2] |=> post_divider_stop[12])
    else $error("code 0x5F did not stop synth 3 divider D bit0");

  chk_stop_reg_or: assert property (@(posedge clk) disable iff (!rst_n)
    post_divider_stop_reg_q[15] ##1 post_divider_stop_reg_q[15] |-> ##1 post_divider_stop[15])
    else $error("stop register bit not seen on the stop output");

  chk_diff0_enable: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_role_select_reg_q[1] == 8'h60 && pin_in[1])[*2] |=> diff_output_enable[0])
    else $error("code 0x60 did not enable differential output 0");

  chk_diff7_enable: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_role_select_reg_q[1] == 8'h6E && pin_in[1])[*2] |=> diff_output_enable[7])
    else $error("code 0x6E did not enable differential output 7");

  chk_se0_enable: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_role_select_reg_q[2] == 8'h70 && pin_in[2])[*2] |=> single_ended_output_enable[0])
    else $error("code 0x70 did not enable single-ended output 0");

  chk_se7_enable: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_role_select_reg_q[2] == 8'h7E && pin_in[2])[*2] |=> single_ended_output_enable[7])
    else $error("code 0x7E did not enable single-ended output 7");

  chk_irq_pin_level: assert property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[3] == 8'h80 |=> pin_oe[3] && pin_out[3] == $past(irq_q))
    else $error("interrupt role pin does not follow the interrupt");

  chk_precise_pin: assert property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[2] == 8'h88 |=> pin_oe[2] && pin_out[2] == $past(reference_input_0_precise_fail))
    else $error("precise check role pin mismatch");

  chk_cycle_pin: assert property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[2] == 8'h89 |=> pin_oe[2] && pin_out[2] == $past(reference_input_0_cycle_fail))
    else $error("single-cycle role pin mismatch");

  chk_coarse_pin: assert property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[2] == 8'h8A |=> pin_oe[2] && pin_out[2] == $past(reference_input_0_coarse_fail))
    else $error("coarse check role pin mismatch");

  chk_guard_pin: assert property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[2] == 8'h8B |=> pin_oe[2] && pin_out[2] == $past(reference_input_0_guard_soak))
    else $error("guard soak role pin mismatch");

  chk_plain_input: assert property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[4] == 8'h00
    |=> !pin_oe[4] && stop_vec[4] == 16'h0000 && diff_vec[4] == 8'h00 && se_vec[4] == 8'h00)
    else $error("code zero pin is not a plain input");

  chk_unassigned_code: assert property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[4] == 8'h48
    |=> !pin_oe[4] && stop_vec[4] == 16'h0000 && diff_vec[4] == 8'h00 && se_vec[4] == 8'h00)
    else $error("unassigned code had an effect");

  cov_stop_by_pin: cover property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[5] == 8'h44 && pin_in[5] ##2 post_divider_stop[3]);

  cov_irq_on_pin: cover property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[3] == 8'h80 ##1 pin_out[3]);

  cov_status_clear: cover property (@(posedge clk) disable iff (!rst_n)
    irq ##[1:20] !irq);

  cov_enable_or: cover property (@(posedge clk) disable iff (!rst_n)
    diff_output_enable_reg_q[7] && diff_output_enable[0]);

  cov_status_pin: cover property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[2] == 8'h8B && pin_out[2]);

  //////////////////////////////////////////////////////////////////////////
  // bus handshake, interrupt and register checks
  chk_wait_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest stayed low for more than one cycle");

  chk_wait_answers: assert property (@(posedge clk) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request was not answered in the next cycle");

  chk_role_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (req_take && avs_read && avs_address == gfs_pkg::OFS_ROLE0)
    |=> avs_readdata == {24'h00_0000, $past(pin_role_select_reg_q[0])})
    else $error("pin 0 role read returned the wrong code");

  chk_readdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(req_take && avs_read) |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  chk_status_no_control: assert property (@(posedge clk) disable iff (!rst_n)
    pin_role_select_reg_q[2][7]
    |=> stop_vec[2] == 16'h0000 && diff_vec[2] == 8'h00 && se_vec[2] == 8'h00)
    else $error("status role pin touched a control");

  chk_status_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ev_rise != 4'h0 |=> (irq_status_q & $past(ev_rise)) == $past(ev_rise))
    else $error("indicator rise did not set its status bit");

  chk_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> irq == $past(|(irq_status_q & irq_mask_q)))
    else $error("interrupt does not follow masked status");

  chk_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_fire && avs_address == gfs_pkg::OFS_IRQ_MASK) |=> irq_mask_q == $past(avs_writedata[3:0]))
    else $error("mask register did not take the written value");

  chk_diff_reg_or: assert property (@(posedge clk) disable iff (!rst_n)
    diff_output_enable_reg_q[7] ##1 diff_output_enable_reg_q[7] |-> ##1 diff_output_enable[7])
    else $error("differential enable register bit not seen on the output");

  chk_se_reg_or: assert property (@(posedge clk) disable iff (!rst_n)
    single_ended_output_enable_reg_q[6] ##1 single_ended_output_enable_reg_q[6]
    |-> ##1 single_ended_output_enable[6])
    else $error("single-ended enable register bit not seen on the output");
endmodule : gfs_gpio_function_select

// [rtl/gfs_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - each pin role comes from all eight code bits of its select register
// - stop-clock codes sit at 0x44+8n: C bit1, C bit0, D bit1, D bit0
// - role 0x60 ORs the pin level into differential output 0 enable
// - even codes 0x62..0x6E enable differential outputs 1..7 the same way
// - role 0x70 ORs the pin level into single-ended output 0 enable
// - even codes 0x72..0x7E enable single-ended outputs 1..7 the same way
// - role 0x80 drives the pin high while the interrupt is asserted
// - role 0x88 drives the pin with the reference 0 precise check failure
// - role 0x89 drives the pin with the reference 0 single-cycle indicator
// - role 0x8A drives the pin with the reference 0 coarse indicator
// - role 0x8B drives the pin with the reference 0 guard soak indicator
// - a stop-clock pin level is ORed with its matching stop register bit
// - code zero leaves the pin a plain input with no function
//////////////////////////////////////////////////////////////////////////////
package gfs_pkg;
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned ROLE_W = 8;
  localparam int unsigned STOP_W = 16;
  localparam int unsigned OUT_W = 8;
  localparam int unsigned EV_W = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // byte offsets on the register bus
  localparam logic [7:0] OFS_ROLE0 = 8'h00;
  localparam logic [7:0] OFS_DIFF_EN = 8'h20;
  localparam logic [7:0] OFS_SE_EN = 8'h24;
  localparam logic [7:0] OFS_STOP = 8'h28;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFS_EFF_EN = 8'h34;
  localparam logic [7:0] OFS_EFF_STOP = 8'h38;
  // reset values
  localparam logic [7:0] RST_ROLE = 8'h00;
  localparam logic [7:0] RST_OUT_EN = 8'h00;
  localparam logic [15:0] RST_STOP = 16'h0000;
  localparam logic [3:0] RST_EV = 4'h0;
  // role codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_STOP_FIRST = 8'h44;
  localparam logic [7:0] CODE_STOP_LAST = 8'h5F;
  localparam logic [7:0] CODE_DIFF_FIRST = 8'h60;
  localparam logic [7:0] CODE_DIFF_LAST = 8'h6E;
  localparam logic [7:0] CODE_SE_FIRST = 8'h70;
  localparam logic [7:0] CODE_SE_LAST = 8'h7E;
  localparam logic [7:0] CODE_IRQ = 8'h80;
  localparam logic [7:0] CODE_PRECISE = 8'h88;
  localparam logic [7:0] CODE_CYCLE = 8'h89;
  localparam logic [7:0] CODE_COARSE = 8'h8A;
  localparam logic [7:0] CODE_GUARD = 8'h8B;
  // event bit positions in the interrupt status register
  localparam int unsigned EV_PRECISE = 0;
  localparam int unsigned EV_CYCLE = 1;
  localparam int unsigned EV_COARSE = 2;
  localparam int unsigned EV_GUARD = 3;

  // stop codes use the upper four slots of each eight-code group
  function automatic logic stop_hit(input logic [7:0] code);
    stop_hit = (code >= CODE_STOP_FIRST) && (code <= CODE_STOP_LAST) && code[2];
  endfunction : stop_hit

  // synth n owns bits 4n+3..4n: C bit1, C bit0, D bit1, D bit0
  function automatic logic [3:0] stop_index(input logic [7:0] code);
    stop_index = {code[4:3], ~code[1:0]};
  endfunction : stop_index

  function automatic logic even_hit(input logic [7:0] code, input logic [7:0] first,
                                    input logic [7:0] last);
    even_hit = (code >= first) && (code <= last) && !code[0];
  endfunction : even_hit
endpackage : gfs_pkg

// [rtl/gfs_pin_role_decode.sv]
`timescale 1ns/1ps
module gfs_pin_role_decode
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] role,
  input wire logic pin_level,
  input wire logic irq_level,
  input wire logic precise_fail,
  input wire logic cycle_fail,
  input wire logic coarse_fail,
  input wire logic guard_soak,
  output logic [15:0] stop_vec_q,
  output logic [7:0] diff_vec_q,
  output logic [7:0] se_vec_q,
  output logic drive_level_q,
  output logic drive_en_q
);
  logic [15:0] stop_vec_d;
  logic [7:0] diff_vec_d;
  logic [7:0] se_vec_d;
  logic drive_level_d;
  logic drive_en_d;

  always_comb
  begin
    stop_vec_d = gfs_pkg::RST_STOP;
    diff_vec_d = gfs_pkg::RST_OUT_EN;
    se_vec_d = gfs_pkg::RST_OUT_EN;
    drive_level_d = 1'b0;
    drive_en_d = 1'b0;
    if (gfs_pkg::stop_hit(role))
    begin
      stop_vec_d[gfs_pkg::stop_index(role)] = pin_level;
    end
    if (gfs_pkg::even_hit(role, gfs_pkg::CODE_DIFF_FIRST, gfs_pkg::CODE_DIFF_LAST))
    begin
      diff_vec_d[role[3:1]] = pin_level;
    end
    if (gfs_pkg::even_hit(role, gfs_pkg::CODE_SE_FIRST, gfs_pkg::CODE_SE_LAST))
    begin
      se_vec_d[role[3:1]] = pin_level;
    end
    case (role)
      gfs_pkg::CODE_IRQ:
      begin
        drive_en_d = 1'b1;
        drive_level_d = irq_level;
      end
      gfs_pkg::CODE_PRECISE:
      begin
        drive_en_d = 1'b1;
        drive_level_d = precise_fail;
      end
      gfs_pkg::CODE_CYCLE:
      begin
        drive_en_d = 1'b1;
        drive_level_d = cycle_fail;
      end
      gfs_pkg::CODE_COARSE:
      begin
        drive_en_d = 1'b1;
        drive_level_d = coarse_fail;
      end
      gfs_pkg::CODE_GUARD:
      begin
        drive_en_d = 1'b1;
        drive_level_d = guard_soak;
      end
      default:
      begin
        // code zero and unassigned codes: input only
        drive_en_d = 1'b0;
        drive_level_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stop_vec_q <= gfs_pkg::RST_STOP;
      diff_vec_q <= gfs_pkg::RST_OUT_EN;
      se_vec_q <= gfs_pkg::RST_OUT_EN;
      drive_level_q <= 1'b0;
      drive_en_q <= 1'b0;
    end
    else
    begin
      stop_vec_q <= stop_vec_d;
      diff_vec_q <= diff_vec_d;
      se_vec_q <= se_vec_d;
      drive_level_q <= drive_level_d;
      drive_en_q <= drive_en_d;
    end
  end
endmodule : gfs_pin_role_decode

// [bench/gfs_board_model.sv]
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// board side of the general pins: drives a pin only while the block does not
module gfs_board_model
(
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] board_drv,
  output logic [7:0] pin_in
);
  // wire level resolves to the block's drive where enabled, else the board's
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_in[i] = (pin_oe[i] === 1'b1) ? pin_out[i] : board_drv[i];
    end
  end
endmodule : gfs_board_model

// [bench/gfs_gpio_function_select_test.sv]
`timescale 1ns/1ps
module gfs_gpio_function_select_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] board_drv = 8'h00;
  logic [3:0] ind = 4'h0;
  logic [15:0] stop;
  logic [7:0] diff_en;
  logic [7:0] se_en;
  logic irq;
  logic [31:0] rd;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  gfs_gpio_function_select dut
  (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .reference_input_0_precise_fail(ind[0]), .reference_input_0_cycle_fail(ind[1]), .reference_input_0_coarse_fail(ind[2]),
    .reference_input_0_guard_soak(ind[3]), .post_divider_stop(stop), .diff_output_enable(diff_en),
    .single_ended_output_enable(se_en), .irq(irq)
  );

  gfs_board_model board
  (
    .pin_out(pin_out), .pin_oe(pin_oe), .board_drv(board_drv), .pin_in(pin_in)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("ERROR at %0t: timeout", $time);
      conclude();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // one bus transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check(32'(n), 32'h0000_0002, "bus answer latency");
  endtask : bus

  task automatic set_role(input int pin, input logic [7:0] code);
    bus(1'b1, gfs_pkg::OFS_ROLE0 + 8'(4 * pin), {24'h00_0000, code});
  endtask : set_role

  // decoder flop then or flop, plus the role update edge
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask : settle

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [7:0] ofs [9] = '{8'h00, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38};
    foreach (ofs[i])
    begin
      bus(1'b0, ofs[i], 32'h0000_0000);
      check(rd, 32'h0000_0000, "reset value");
    end
    bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h3C, 32'h0000_0000);
    check(rd, 32'h0000_0000, "unmapped read");
    set_role(7, 8'h8B);
    bus(1'b0, 8'h1C, 32'h0000_0000);
    check(rd, 32'h0000_008B, "role readback");
    set_role(7, 8'h00);
  endtask : test_regs

  task automatic test_stop();
    for (int n = 0; n < 4; n++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        set_role(5, 8'h44 + 8'(8 * n + k));
        board_drv <= 8'h20;
        settle();
        check(32'(stop), 32'h0000_0001 << (4 * n + 3 - k), "stop code");
        board_drv <= 8'h00;
        settle();
        check(32'(stop), 32'h0000_0000, "stop released");
      end
    end
    bus(1'b1, gfs_pkg::OFS_STOP, 32'h0000_8000);
    set_role(5, 8'h44);
    board_drv <= 8'h20;
    settle();
    check(32'(stop), 32'h0000_8008, "stop or");
    bus(1'b0, gfs_pkg::OFS_EFF_STOP, 32'h0000_0000);
    check(rd, 32'h0000_8008, "stop readback");
    board_drv <= 8'h00;
    bus(1'b1, gfs_pkg::OFS_STOP, 32'h0000_0000);
    set_role(5, 8'h00);
  endtask : test_stop

  task automatic test_enables();
    for (int k = 0; k < 8; k++)
    begin
      set_role(1, 8'h60 + 8'(2 * k));
      set_role(2, 8'h70 + 8'(2 * k));
      board_drv <= 8'h06;
      settle();
      check(32'(diff_en), 32'h0000_0001 << k, "diff enable");
      check(32'(se_en), 32'h0000_0001 << k, "se enable");
      board_drv <= 8'h00;
      settle();
      check(32'({se_en, diff_en}), 32'h0000_0000, "enables released");
    end
    set_role(1, 8'h60);
    set_role(2, 8'h70);
    bus(1'b1, gfs_pkg::OFS_DIFF_EN, 32'h0000_0080);
    bus(1'b1, gfs_pkg::OFS_SE_EN, 32'h0000_0040);
    board_drv <= 8'h06;
    settle();
    bus(1'b0, gfs_pkg::OFS_EFF_EN, 32'h0000_0000);
    check(rd, 32'h0000_4181, "enable or");
    board_drv <= 8'h00;
    bus(1'b1, gfs_pkg::OFS_DIFF_EN, 32'h0000_0000);
    bus(1'b1, gfs_pkg::OFS_SE_EN, 32'h0000_0000);
    set_role(1, 8'h00);
    set_role(2, 8'h00);
  endtask : test_enables

  task automatic test_status();
    for (int k = 0; k < 4; k++)
    begin
      set_role(2, 8'h88 + 8'(k));
      ind <= ~(4'h1 << k);
      settle();
      check(32'({pin_oe[2], pin_out[2]}), 32'h0000_0002, "other indicators");
      ind <= 4'h1 << k;
      settle();
      check(32'({pin_oe[2], pin_out[2]}), 32'h0000_0003, "indicator");
      ind <= 4'h0;
      settle();
    end
    set_role(2, 8'h00);
    bus(1'b1, gfs_pkg::OFS_IRQ_STAT, 32'h0000_000F);
  endtask : test_status

  task automatic test_irq();
    set_role(3, 8'h80);
    bus(1'b1, gfs_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    ind <= 4'h3;
    settle();
    bus(1'b0, gfs_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0003, "status set");
    check(32'({irq, pin_oe[3], pin_out[3]}), 32'h0000_0007, "irq on pin");
    bus(1'b1, gfs_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    settle();
    check(32'({irq, pin_oe[3], pin_out[3]}), 32'h0000_0002, "masked bit");
    bus(1'b1, gfs_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    settle();
    check(32'({irq, pin_out[3]}), 32'h0000_0003, "unmasked bit");
    bus(1'b1, gfs_pkg::OFS_IRQ_STAT, 32'h0000_0002);
    settle();
    check(32'({irq, pin_out[3]}), 32'h0000_0000, "cleared");
    ind <= 4'h0;
    bus(1'b1, gfs_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    set_role(3, 8'h00);
  endtask : test_irq

  task automatic test_unassigned();
    logic [7:0] codes [9] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h48, 8'h61, 8'h71, 8'h84, 8'hC0};
    board_drv <= 8'hFF;
    foreach (codes[i])
    begin
      set_role(4, codes[i]);
      settle();
      check(32'(pin_oe), 32'h0000_0000, "no drive");
      check({stop, diff_en, se_en}, 32'h0000_0000, "no control");
    end
    board_drv <= 8'h00;
    set_role(4, 8'h00);
  endtask : test_unassigned

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_regs();
    test_stop();
    test_enables();
    test_status();
    test_irq();
    test_unassigned();
    conclude();
  end
endmodule : gfs_gpio_function_select_test
